// file: spsr_pkg.sv
// Purpose: Shared constants for the switch port status register block
// Assumes: 32-bit AXI4-Lite register bus, single clock
// Notes:   Offsets and field positions live here only
package spsr_pkg;
  // Register byte offsets
  localparam logic [7:0] SPSR_OFF_STATUS = 8'h00;  // Port status
  localparam logic [7:0] SPSR_OFF_IRQ_ST = 8'h04;  // Event status, write one to clear
  localparam logic [7:0] SPSR_OFF_IRQ_MK = 8'h08;  // Event mask
  // Status field positions
  localparam int SPSR_B_STARTED = 0;   // Mode change started flag
  localparam int SPSR_B_DONE    = 1;   // Mode change done flag
  localparam int SPSR_B_LINK    = 4;   // Link up flag
  localparam int SPSR_B_LANEDIR = 5;   // Lane direction
  localparam int SPSR_B_MODE_LO = 6;   // Mode field low bit
  localparam int SPSR_B_PART_LO = 10;  // Partition field low bit
  localparam int SPSR_B_DEV_LO  = 16;  // Device number low bit
  // Event bits in interrupt status and mask
  localparam int SPSR_EV_STARTED = 0;  // Mode change started
  localparam int SPSR_EV_DONE    = 1;  // Mode change done
  localparam int SPSR_EV_LINK    = 2;  // Link up state changed
  localparam int SPSR_EV_W       = 3;  // Event count
  // Lane direction codes
  localparam logic SPSR_LANE_UP = 1'h0;  // Upstream lanes
  localparam logic SPSR_LANE_DN = 1'h1;  // Downstream lanes
  // AXI responses
  localparam logic [1:0] SPSR_RESP_OK  = 2'h0;  // OKAY
  localparam logic [1:0] SPSR_RESP_ERR = 2'h2;  // SLVERR for unmapped address
  // Port mode encoding
  typedef enum logic [2:0] {
    SPSR_MODE_DISABLED = 3'b000,  // Disabled
    SPSR_MODE_DOWN     = 3'b001,  // Downstream port
    SPSR_MODE_UP       = 3'b010,  // Upstream port
    SPSR_MODE_NTB      = 3'b011,  // Non-transparent endpoint
    SPSR_MODE_UP_NTB   = 3'b100,  // Upstream with non-transparent endpoint
    SPSR_MODE_UNATT    = 3'b101   // Unattached
  } spsr_mode_e;
  // Mode change tracking
  typedef enum logic [1:0] {
    SPSR_ST_IDLE = 2'b00,  // Effective mode matches target
    SPSR_ST_BUSY = 2'b01,  // Change under way
    SPSR_ST_DONE = 2'b10   // Change applied this cycle
  } spsr_state_e;
endpackage : spsr_pkg

// file: spsr_sync.sv
// Purpose: Two-flop synchroniser for a bundle of levels
// Assumes: Inputs are quasi-static levels
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module spsr_sync #(
  parameter int W = 1  // Bundle width
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;  // First stage
    logic [W-1:0] s2;  // Second stage
  } spsr_sync_s;
  spsr_sync_s st_ff;    // Registered state
  spsr_sync_s nxt_st;   // Next state

  // Shift chain
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  // Synchronous reset to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule : spsr_sync

// file: spsr_top.sv
// Purpose: Switch port status register with AXI4-Lite access
// Assumes: Port state inputs come from outside the clock domain
// Notes:   Sticky flags survive aresetn, cleared by fund_reset_n or by writing one
// Notes:   Read answers one cycle after address, write two after both halves
// Functional notes
// - Set started flag when mode change begins
// - Set done flag when mode change ends
// - Bit 4 shows data link up
// - Bit 5 shows lane direction, up 0
// - Lane direction follows training, not mode
// - Bits 8:6 report effective port mode
// - Disabled partition forces disabled mode report
// - Reported mode lags during partition change
// - Bits 13:10 report effective partition
// - Bits 20:16 report downstream device number
// - Codes 3 and 4 are NTB modes
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module spsr_top
  import spsr_pkg::*;
#(
  parameter int SETTLE_CYC = 8  // Cycles a mode change takes to apply
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                fund_reset_n,
  input  wire logic [2:0]          cfg_mode,
  input  wire logic [3:0]          cfg_partition,
  input  wire logic [4:0]          cfg_dev_num,
  input  wire logic                partition_enabled,
  input  wire logic                dl_up,
  input  wire logic                trained_downstream,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic                     irq
);
  import spsr_pkg::*;

  // Elaboration check: the settle field is eight bits wide
  if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_bad_settle
    $error("SETTLE_CYC out of range");
  end

  localparam int SYNC_W = 3 + 4 + 5 + 1 + 1 + 1;  // Synchronised bundle width

  // Synchronised inputs
  logic [SYNC_W-1:0] sync_q;        // Synchroniser output
  logic [2:0]        s_mode;        // Programmed mode
  logic [3:0]        s_part;        // Programmed partition
  logic [4:0]        s_dev;         // Programmed device number
  logic              s_part_en;     // Partition enabled
  logic              s_dl_up;       // Data link up
  logic              s_lane_dn;     // Trained as downstream

  // Port levels cross clock domains; two flops guard metastability
  spsr_sync #(.W(SYNC_W)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({cfg_mode, cfg_partition, cfg_dev_num, partition_enabled, dl_up, trained_downstream}),
    .q       (sync_q)
  );
  assign {s_mode, s_part, s_dev, s_part_en, s_dl_up, s_lane_dn} = sync_q;

  // Block state, reset by aresetn
  typedef struct packed {
    spsr_state_e      state;     // Mode change tracker
    logic [7:0]       settle;    // Settle countdown
    logic [2:0]       eff_mode;  // Mode in effect
    logic [3:0]       eff_part;  // Partition in effect
    logic [4:0]       eff_dev;   // Device number in effect
    logic             link;      // Link up
    logic             lane;      // Lane direction
    logic             link_d;    // Previous link, for edge event
    logic [SPSR_EV_W-1:0] mask;  // Interrupt mask
    logic             awv;       // Write address held
    logic [7:0]       awa;       // Held write address
    logic             wv;        // Write data held
    logic [31:0]      wd;        // Held write data
    logic [3:0]       ws;        // Held strobes
    logic             bv;        // Write response valid
    logic [1:0]       br;        // Write response code
    logic             rv;        // Read data valid
    logic [31:0]      rd;        // Read data
    logic [1:0]       rr;        // Read response code
    logic             aw_rdy;    // Write address ready
    logic             w_rdy;     // Write data ready
    logic             ar_rdy;    // Read address ready
    logic             irq;       // Interrupt output
  } spsr_s;

  // Sticky state, reset only by fundamental reset
  typedef struct packed {
    logic [1:0]           flags;  // Started and done flags
    logic [SPSR_EV_W-1:0] ev;     // Interrupt event status
  } spsr_sticky_s;

  spsr_s        st_ff;       // Registered state
  spsr_s        nxt_st;      // Next state
  spsr_sticky_s sk_ff;       // Registered sticky state
  spsr_sticky_s nxt_sk;      // Next sticky state

  // Working values
  logic [2:0]  tgt_mode;     // Mode the port should assume
  logic        ev_start;     // Mode change begins
  logic        ev_done;      // Mode change ends
  logic        ev_link;      // Link state changed
  logic        wr_go;        // Write performed this cycle
  logic [31:0] wmask;        // Byte mask from strobes
  logic [31:0] status_word;  // Assembled status register
  logic [1:0]  clr_flags;    // Flags cleared by write
  logic [SPSR_EV_W-1:0] clr_ev;  // Events cleared by write

  // Target mode: disabled partition forces disabled
  always_comb begin
    if (!s_part_en) begin
      tgt_mode = SPSR_MODE_DISABLED;
    end else begin
      // Reserved codes keep the mode in effect rather than guess
      case (s_mode)
        SPSR_MODE_DISABLED, SPSR_MODE_DOWN, SPSR_MODE_UP,
        SPSR_MODE_NTB, SPSR_MODE_UP_NTB, SPSR_MODE_UNATT: begin
          tgt_mode = s_mode;
        end
        default: begin
          tgt_mode = st_ff.eff_mode;  // Reserved code is ignored
        end
      endcase
    end
  end

  // Status word assembly
  always_comb begin
    status_word = '0;
    status_word[SPSR_B_STARTED] = sk_ff.flags[0];
    status_word[SPSR_B_DONE]    = sk_ff.flags[1];
    status_word[SPSR_B_LINK]    = st_ff.link;
    status_word[SPSR_B_LANEDIR] = st_ff.lane;
    status_word[SPSR_B_MODE_LO +: 3] = st_ff.eff_mode;
    status_word[SPSR_B_PART_LO +: 4] = st_ff.eff_part;
    status_word[SPSR_B_DEV_LO +: 5]  = st_ff.eff_dev;
  end

  // Next state of the whole block
  always_comb begin
    nxt_st    = st_ff;
    ev_start  = 1'b0;
    ev_done   = 1'b0;
    wr_go     = 1'b0;
    clr_flags = '0;
    clr_ev    = '0;
    wmask     = {{8{st_ff.ws[3]}}, {8{st_ff.ws[2]}}, {8{st_ff.ws[1]}}, {8{st_ff.ws[0]}}};
    // Mode change tracker
    case (st_ff.state)
      SPSR_ST_IDLE: begin
        if (tgt_mode != st_ff.eff_mode) begin
          ev_start      = 1'b1;
          nxt_st.state  = SPSR_ST_BUSY;
          nxt_st.settle = 8'(SETTLE_CYC - 1);
        end else begin
          nxt_st.eff_part = s_part;  // Partition follows when stable
          nxt_st.eff_dev  = s_dev;
        end
      end
      SPSR_ST_BUSY: begin
        if (st_ff.settle == 8'h00) begin
          nxt_st.eff_mode = tgt_mode;
          nxt_st.eff_part = s_part;
          nxt_st.eff_dev  = s_dev;
          nxt_st.state    = SPSR_ST_DONE;
        end else begin
          nxt_st.settle = st_ff.settle - 8'h01;  // Old values stay meanwhile
        end
      end
      SPSR_ST_DONE: begin
        ev_done      = 1'b1;
        nxt_st.state = SPSR_ST_IDLE;
      end
      default: begin
        nxt_st.state = SPSR_ST_IDLE;
      end
    endcase
    // Link and trained lane direction
    nxt_st.link   = s_dl_up;
    nxt_st.link_d = st_ff.link;
    if (s_dl_up) begin
      nxt_st.lane = s_lane_dn ? SPSR_LANE_DN : SPSR_LANE_UP;
    end
    // Link event fires once per change of the registered link bit
    ev_link = st_ff.link ^ st_ff.link_d;
    // Write channel capture in either order
    if (st_ff.aw_rdy && s_axi_awvalid) begin
      nxt_st.awv = 1'b1;
      nxt_st.awa = s_axi_awaddr;
    end
    if (st_ff.w_rdy && s_axi_wvalid) begin
      nxt_st.wv = 1'b1;
      nxt_st.wd = s_axi_wdata;
      nxt_st.ws = s_axi_wstrb;
    end
    // Perform write once both halves held
    wr_go = st_ff.awv && st_ff.wv && !st_ff.bv;
    if (wr_go) begin
      nxt_st.awv = 1'b0;
      nxt_st.wv  = 1'b0;
      nxt_st.bv  = 1'b1;
      nxt_st.br  = SPSR_RESP_OK;
      // Word decode; byte address bits below the word are ignored
      case ({st_ff.awa[7:2], 2'b00})
        SPSR_OFF_STATUS: begin
          clr_flags = 2'(st_ff.wd[1:0] & wmask[1:0]);
        end
        SPSR_OFF_IRQ_ST: begin
          clr_ev = st_ff.wd[SPSR_EV_W-1:0] & wmask[SPSR_EV_W-1:0];
        end
        SPSR_OFF_IRQ_MK: begin
          nxt_st.mask = (st_ff.mask & ~wmask[SPSR_EV_W-1:0])
                      | (st_ff.wd[SPSR_EV_W-1:0] & wmask[SPSR_EV_W-1:0]);
        end
        default: begin
          nxt_st.br = SPSR_RESP_ERR;  // Unmapped
        end
      endcase
    end
    if (st_ff.bv && s_axi_bready) begin
      nxt_st.bv = 1'b0;
    end
    // Read channel
    if (st_ff.ar_rdy && s_axi_arvalid) begin
      nxt_st.rv = 1'b1;
      nxt_st.rr = SPSR_RESP_OK;
      case ({s_axi_araddr[7:2], 2'b00})
        SPSR_OFF_STATUS: nxt_st.rd = status_word;
        SPSR_OFF_IRQ_ST: nxt_st.rd = {{(32-SPSR_EV_W){1'b0}}, sk_ff.ev};
        SPSR_OFF_IRQ_MK: nxt_st.rd = {{(32-SPSR_EV_W){1'b0}}, st_ff.mask};
        default: begin
          nxt_st.rd = '0;
          nxt_st.rr = SPSR_RESP_ERR;
        end
      endcase
    end else if (st_ff.rv && s_axi_rready) begin
      nxt_st.rv = 1'b0;
    end
    // Readies registered so every bus output leaves a flop
    nxt_st.aw_rdy = !nxt_st.awv;
    nxt_st.w_rdy  = !nxt_st.wv;
    nxt_st.ar_rdy = !nxt_st.rv;
    // Sticky flags: set wins over clear
    // A change starting in the clear cycle must not be lost
    nxt_sk       = sk_ff;
    nxt_sk.flags = (sk_ff.flags & ~clr_flags) | {ev_done, ev_start};
    nxt_sk.ev    = (sk_ff.ev & ~clr_ev) | {ev_link, ev_done, ev_start};
    // Next values used so irq follows status with no extra lag
    nxt_st.irq   = |(nxt_sk.ev & nxt_st.mask);
  end

  // Main registers, device reset
  // Device reset returns the tracker to idle with mode disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Sticky registers, fundamental reset only
  // Software can still see a mode change across a device reset
  always_ff @(posedge aclk) begin
    if (!fund_reset_n) begin
      sk_ff <= '0;
    end else begin
      sk_ff <= nxt_sk;
    end
  end

  // Bus outputs straight from flops
  // Readies stay low while a slot is occupied and during reset
  assign s_axi_awready = st_ff.aw_rdy;
  assign s_axi_wready  = st_ff.w_rdy;
  assign s_axi_bvalid  = st_ff.bv;
  assign s_axi_bresp   = st_ff.br;
  assign s_axi_arready = st_ff.ar_rdy;
  assign s_axi_rvalid  = st_ff.rv;
  assign s_axi_rdata   = st_ff.rd;
  assign s_axi_rresp   = st_ff.rr;
  assign irq           = st_ff.irq;
endmodule : spsr_top

// file: spsr_properties.sv
// Purpose: Port-level assertions for the port status register
// Assumes: One clock, aresetn active-low synchronous
// Notes:   Bound into spsr_top
`timescale 1ns/1ps
module spsr_properties
  import spsr_pkg::*;
#(
  parameter int SETTLE_CYC = 8  // Mode change settle time
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [2:0]  cfg_mode,
  input wire logic [3:0]  cfg_partition,
  input wire logic [4:0]  cfg_dev_num,
  input wire logic        partition_enabled,
  input wire logic        dl_up,
  input wire logic        trained_downstream,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp
);
  logic [7:0] addr_ff;   // Address of read in flight
  logic [7:0] quiet_ff;  // Cycles control inputs held
  logic [2:0] lq_ff;     // Cycles link inputs held
  logic       rd0;       // Status word on read channel
  logic       settled;   // Mode change surely over
  // Track read address and input quiet time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_ff  <= 8'h00;
      quiet_ff <= 8'h00;
      lq_ff    <= 3'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) addr_ff <= s_axi_araddr;
      if (!$stable({cfg_mode, cfg_partition, cfg_dev_num, partition_enabled})) quiet_ff <= 8'h00;
      else if (quiet_ff != 8'hFF) quiet_ff <= quiet_ff + 8'h01;
      if (!$stable({dl_up, trained_downstream})) lq_ff <= 3'h0;
      else if (lq_ff != 3'h7) lq_ff <= lq_ff + 3'h1;
    end
  end
  assign rd0     = s_axi_rvalid && addr_ff == SPSR_OFF_STATUS && s_axi_rresp == SPSR_RESP_OK;
  assign settled = int'(quiet_ff) >= SETTLE_CYC + 10;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rsvd_zero: assert property (rd0 |-> s_axi_rdata[31:21] == 11'h0 && s_axi_rdata[15:14] == 2'h0
    && !s_axi_rdata[9] && s_axi_rdata[3:2] == 2'h0) else $error("reserved bits set");
  chk_mode_legal: assert property (rd0 |-> s_axi_rdata[8:6] <= 3'h5)
    else $error("mode code out of range");
  chk_link_bit: assert property (rd0 && lq_ff == 3'h7 |-> s_axi_rdata[4] == dl_up)
    else $error("link bit wrong");
  chk_lane_dir: assert property (rd0 && lq_ff == 3'h7 && dl_up |-> s_axi_rdata[5] == trained_downstream)
    else $error("lane direction wrong");
  chk_mode_off: assert property (rd0 && settled && !partition_enabled |-> s_axi_rdata[8:6] == 3'h0)
    else $error("mode not disabled");
  chk_mode_echo: assert property (rd0 && settled && partition_enabled && cfg_mode <= 3'h5
    |-> s_axi_rdata[8:6] == cfg_mode) else $error("mode not applied");
  chk_part_field: assert property (rd0 && settled && partition_enabled && cfg_mode inside {[3'h1:3'h4]}
    |-> s_axi_rdata[13:10] == cfg_partition) else $error("partition wrong");
  chk_dev_field: assert property (rd0 && settled && partition_enabled && cfg_mode == 3'h1
    |-> s_axi_rdata[20:16] == cfg_dev_num) else $error("device number wrong");
endmodule : spsr_properties
bind spsr_top spsr_properties #(.SETTLE_CYC(SETTLE_CYC)) u_props (
  .aclk               (aclk),
  .aresetn            (aresetn),
  .cfg_mode           (cfg_mode),
  .cfg_partition      (cfg_partition),
  .cfg_dev_num        (cfg_dev_num),
  .partition_enabled  (partition_enabled),
  .dl_up              (dl_up),
  .trained_downstream (trained_downstream),
  .s_axi_araddr       (s_axi_araddr),
  .s_axi_arvalid      (s_axi_arvalid),
  .s_axi_arready      (s_axi_arready),
  .s_axi_rdata        (s_axi_rdata),
  .s_axi_rresp        (s_axi_rresp),
  .s_axi_rvalid       (s_axi_rvalid),
  .s_axi_rready       (s_axi_rready),
  .s_axi_bvalid       (s_axi_bvalid),
  .s_axi_bready       (s_axi_bready),
  .s_axi_bresp        (s_axi_bresp)
);

// file: test_spsr_top.sv
// Purpose: Self-checking bench for the port status register
// Assumes: Bench signals share the port names of spsr_top
// Notes:   Register traffic goes through one bus task
`timescale 1ns/1ps
module test_spsr_top;
  import spsr_pkg::*;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
  logic        aclk, aresetn, fund_reset_n, partition_enabled, dl_up, trained_downstream, irq;
  logic [2:0]  cfg_mode;
  logic [3:0]  cfg_partition, s_axi_wstrb;
  logic [4:0]  cfg_dev_num;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          errors, checks;
  spsr_top #(.SETTLE_CYC(8)) dut (
    .aclk (aclk), .aresetn (aresetn), .fund_reset_n (fund_reset_n),
    .cfg_mode (cfg_mode), .cfg_partition (cfg_partition), .cfg_dev_num (cfg_dev_num),
    .partition_enabled (partition_enabled), .dl_up (dl_up), .trained_downstream (trained_downstream),
    .s_axi_awaddr (s_axi_awaddr), .s_axi_awvalid (s_axi_awvalid), .s_axi_awready (s_axi_awready),
    .s_axi_wdata (s_axi_wdata), .s_axi_wstrb (s_axi_wstrb), .s_axi_wvalid (s_axi_wvalid),
    .s_axi_wready (s_axi_wready), .s_axi_bresp (s_axi_bresp), .s_axi_bvalid (s_axi_bvalid),
    .s_axi_bready (s_axi_bready), .s_axi_araddr (s_axi_araddr), .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready), .s_axi_rdata (s_axi_rdata), .s_axi_rresp (s_axi_rresp),
    .s_axi_rvalid (s_axi_rvalid), .s_axi_rready (s_axi_rready), .irq (irq)
  );
  // Free-running clock, 40 ns
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Print counts and verdict
  task end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  // One register access; valids held until taken, readies up until the answer
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    s_axi_bready <= 1'b1;
    s_axi_rready <= 1'b1;
    if (w) begin
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
    end else begin
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
    end
    repeat (60) if (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (w ? s_axi_bvalid : s_axi_rvalid) begin
        done = 1'b1;
        rd_d = s_axi_rdata;
        rd_r = w ? s_axi_bresp : s_axi_rresp;
      end
    end
    if (!done) begin
      errors++;
      end_sim();
    end
  endtask : bus
  // Expected status word from its fields
  function automatic logic [31:0] st(logic [2:0] m, logic [3:0] p, logic [4:0] dv);
    return {11'h0, dv, 2'h0, p, 1'b0, m, 6'h03};
  endfunction : st
  // Main sequence
  initial begin
    {aresetn, fund_reset_n, dl_up, trained_downstream, s_axi_awvalid, s_axi_wvalid} = '0;
    {cfg_mode, cfg_partition, cfg_dev_num, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, errors, checks} = '0;
    partition_enabled = 1'b1;
    s_axi_wstrb = 4'hF;
    wt(6);
    aresetn <= 1'b1;
    fund_reset_n <= 1'b1;
    wt(2);
    bus(1'b0, SPSR_OFF_STATUS, 32'h0); `CHK("status", 32'h0, rd_d)
    bus(1'b0, SPSR_OFF_IRQ_MK, 32'h0); `CHK("mask", 32'h0, rd_d)
    bus(1'b0, 8'h0C, 32'h0); `CHK("unmapped", {SPSR_RESP_ERR, 32'h0}, {rd_r, rd_d})
    bus(1'b1, SPSR_OFF_IRQ_MK, 32'h3); `CHK("wr resp", SPSR_RESP_OK, rd_r)
    bus(1'b1, 8'h0C, 32'h0); `CHK("wr unmapped", SPSR_RESP_ERR, rd_r)
    cfg_mode <= SPSR_MODE_DOWN;
    cfg_partition <= 4'h3;
    cfg_dev_num <= 5'h07;
    bus(1'b0, SPSR_OFF_STATUS, 32'h0); `CHK("lag mode", 3'h0, rd_d[8:6])
    wt(30);
    bus(1'b0, SPSR_OFF_STATUS, 32'h0); `CHK("down", st(3'h1, 4'h3, 5'h07), rd_d)
    `CHK("irq set", 1'b1, irq)
    bus(1'b0, SPSR_OFF_IRQ_ST, 32'h0); `CHK("events", 32'h3, rd_d)
    bus(1'b1, SPSR_OFF_STATUS, 32'h3);
    bus(1'b1, SPSR_OFF_IRQ_ST, 32'h7);
    wt(3);
    `CHK("irq clr", 1'b0, irq)
    bus(1'b0, SPSR_OFF_STATUS, 32'h0); `CHK("w1c", 2'h0, rd_d[1:0])
    dl_up <= 1'b1;
    trained_downstream <= 1'b1;
    wt(10);
    bus(1'b0, SPSR_OFF_STATUS, 32'h0); `CHK("link dn", 2'h3, rd_d[5:4])
    `CHK("irq mask", 1'b0, irq)
    bus(1'b1, SPSR_OFF_IRQ_MK, 32'h7);
    wt(3);
    `CHK("irq link", 1'b1, irq)
    s_axi_wstrb <= 4'hE;
    bus(1'b1, SPSR_OFF_IRQ_MK, 32'h0);
    s_axi_wstrb <= 4'hF;
    bus(1'b0, SPSR_OFF_IRQ_MK, 32'h0); `CHK("strobe", 32'h7, rd_d)
    trained_downstream <= 1'b0;
    wt(10);
    bus(1'b0, SPSR_OFF_STATUS, 32'h0); `CHK("link up", 2'h1, rd_d[5:4])
    dl_up <= 1'b0;
    wt(10);
    bus(1'b0, SPSR_OFF_STATUS, 32'h0); `CHK("link off", 1'b0, rd_d[4])
    for (int m = 2; m < 6; m++) begin
      cfg_mode <= 3'(m);
      wt(30);
      bus(1'b0, SPSR_OFF_STATUS, 32'h0); `CHK("mode", 3'(m), rd_d[8:6])
    end
    cfg_mode <= 3'h6;
    wt(30);
    bus(1'b0, SPSR_OFF_STATUS, 32'h0); `CHK("rsvd mode", 3'h5, rd_d[8:6])
    cfg_mode <= SPSR_MODE_DOWN;
    partition_enabled <= 1'b0;
    wt(30);
    bus(1'b0, SPSR_OFF_STATUS, 32'h0); `CHK("part off", 3'h0, rd_d[8:6])
    partition_enabled <= 1'b1;
    cfg_mode <= SPSR_MODE_DISABLED;
    wt(30);
    aresetn <= 1'b0;
    wt(3);
    aresetn <= 1'b1;
    wt(2);
    bus(1'b0, SPSR_OFF_STATUS, 32'h0); `CHK("sticky", 2'h3, rd_d[1:0])
    aresetn <= 1'b0;
    fund_reset_n <= 1'b0;
    wt(3);
    aresetn <= 1'b1;
    fund_reset_n <= 1'b1;
    wt(2);
    bus(1'b0, SPSR_OFF_STATUS, 32'h0); `CHK("fund rst", 2'h0, rd_d[1:0])
    end_sim();
  end
endmodule : test_spsr_top
